// [bsc_exec.sv]
// What this block does
// - skip-if-set opcode 1001 0bbb, bit index and register address
// - tested bit set discards next instruction; nop cycle follows
// - toggle opcode 0011 1bbb; read, invert bit, write in last phase
// - call opcode 111 loads 13-bit literal into pc bits 12..0
// - call pushes pc plus one onto stack before pc changes
// - call copies literal 12..8 and pc 15..13 into page latch
// - call stays within 8K page, takes two cycles, second is nop
// - clear opcode 0010 100s; one cycle, writes zero, no flags
// - select zero clears data location and working register
// - select one clears only the data location
//
// execute unit for skip, toggle, in-page call and clear
// assumes data memory answers a read in the same cycle and pc points
// at the current instruction while it executes
`timescale 1ns/1ps
`include "bsc_params.svh"
module bsc_exec (
  input wire logic ref_clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic [15:0] instr, // fetched instruction word
  input wire logic [15:0] pc_in, // pc of current instruction
  input wire logic [7:0] page_latch_in, // current page latch
  input wire logic [7:0] working_register_in, // current working register
  input wire logic [7:0] mem_rdata, // data memory read data
  output logic [7:0] mem_addr, // data memory address
  output logic mem_rd, // data memory read strobe
  output logic mem_wr, // data memory write strobe
  output logic [7:0] mem_wdata, // data memory write data
  output logic [15:0] pc_out, // new pc value
  output logic pc_load, // load pc_out into pc
  output logic [15:0] stack_top, // value pushed on stack
  output logic stack_push, // push strobe
  output logic [7:0] page_latch_out, // new page latch
  output logic page_latch_load, // load page latch
  output logic [7:0] working_register_out, // new working register
  output logic working_register_load, // load working register
  output logic flush, // discard fetched instruction
  output bsc_pkg::bsc_phase_t phase_out, // phase now shown
  output logic busy_nop // executing a forced nop cycle
);
  import bsc_pkg::*;

  // ==========================================
  // phase and decode
  bsc_phase_t phase;
  logic cycle_end;
  bsc_instr_t kind;

  bsc_phase_gen u_phase (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .phase(phase),
    .cycle_end(cycle_end)
  );

  bsc_decode u_dec (
    .instr(instr),
    .kind(kind)
  );

  // ==========================================
  // execute state
  logic nop_reg, nop_next;
  logic [7:0] data_reg, data_next;
  logic [7:0] mem_addr_reg, mem_addr_next;
  logic mem_rd_reg, mem_rd_next;
  logic mem_wr_reg, mem_wr_next;
  logic [7:0] mem_wdata_reg, mem_wdata_next;
  logic [15:0] pc_out_reg, pc_out_next;
  logic pc_load_reg, pc_load_next;
  logic [15:0] stack_top_reg, stack_top_next;
  logic stack_push_reg, stack_push_next;
  logic [7:0] page_latch_reg, page_latch_next;
  logic page_latch_load_reg, page_latch_load_next;
  logic [7:0] working_register_reg, working_register_next;
  logic working_register_load_reg, working_register_load_next;
  logic flush_reg, flush_next;
  bsc_phase_t phase_reg;
  logic [2:0] bit_idx;
  logic [7:0] bit_mask;
  logic sel_bit;
  logic [15:0] new_pc;
  logic skip_hit;

  assign bit_idx = instr[`BSC_BIT_IDX_LO+2:`BSC_BIT_IDX_LO];
  // mask built eight bits wide so index seven stays inside it
  assign bit_mask = `BSC_BIT_ONE << bit_idx;
  assign sel_bit = instr[`BSC_SEL_BIT];
  // upper pc bits kept, so target stays in page
  assign new_pc = {pc_in[`BSC_PAGE_HI:`BSC_PAGE_LO+1], instr[`BSC_PAGE_LO:0]};
  // tested bit of the operand captured in phase two
  assign skip_hit = (data_reg & bit_mask) != `BSC_BYTE_ZERO;

  // ==========================================
  // sequencing: forced nop cycle and flush
  always_comb
  begin
    nop_next = nop_reg;
    flush_next = 1'b0;
    if (nop_reg)
    begin
      // forced nop: all four phases do nothing
      if (cycle_end)
        nop_next = 1'b0;
    end
    else
    begin
      case (phase)
        BSC_Q4:
        begin
          // tested bit set: drop next fetch, run nop
          if (kind == BSC_I_SKIP && skip_hit)
          begin
            flush_next = 1'b1;
            nop_next = 1'b1;
          end
          // call's second cycle is a nop
          else if (kind == BSC_I_CALL)
          begin
            flush_next = 1'b1;
            nop_next = 1'b1;
          end
        end
        default:
        begin
          flush_next = 1'b0;
        end
      endcase
    end
  end

  // phase_out is registered, so it shows the phase one clock late
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nop_reg <= 1'b0;
      flush_reg <= 1'b0;
      phase_reg <= BSC_Q1;
    end
    else
    begin
      nop_reg <= nop_next;
      flush_reg <= flush_next;
      phase_reg <= phase;
    end
  end

  // ==========================================
  // in-page call: return address, pc and page latch
  always_comb
  begin
    pc_out_next = pc_out_reg;
    pc_load_next = 1'b0;
    stack_top_next = stack_top_reg;
    stack_push_next = 1'b0;
    page_latch_next = page_latch_reg;
    page_latch_load_next = 1'b0;
    // the second, idle cycle of a call must not push again
    if (!nop_reg && kind == BSC_I_CALL)
    begin
      case (phase)
        BSC_Q2:
        begin
          // push return address before pc changes
          stack_top_next = pc_in + `BSC_PC_STEP;
          stack_push_next = 1'b1;
        end
        BSC_Q3:
        begin
          // load literal into low pc bits
          pc_out_next = new_pc;
          pc_load_next = 1'b1;
          // page latch from literal and pc top bits
          page_latch_next = {new_pc[`BSC_PAGE_HI:`BSC_PAGE_LO+1],
            instr[`BSC_PAGE_LO:`BSC_LIT_LO_TOP+1]};
          page_latch_load_next = 1'b1;
        end
        default:
        begin
          pc_load_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_out_reg <= `BSC_PC_RESET;
      pc_load_reg <= 1'b0;
      stack_top_reg <= `BSC_PC_RESET;
      stack_push_reg <= 1'b0;
      page_latch_reg <= `BSC_BYTE_ZERO;
      page_latch_load_reg <= 1'b0;
    end
    else
    begin
      pc_out_reg <= pc_out_next;
      pc_load_reg <= pc_load_next;
      stack_top_reg <= stack_top_next;
      stack_push_reg <= stack_push_next;
      page_latch_reg <= page_latch_next;
      page_latch_load_reg <= page_latch_load_next;
    end
  end

  // ==========================================
  // data memory and working register
  always_comb
  begin
    data_next = data_reg;
    mem_addr_next = instr[`BSC_LIT_LO_TOP:0];
    mem_rd_next = 1'b0;
    mem_wr_next = 1'b0;
    mem_wdata_next = mem_wdata_reg;
    working_register_next = working_register_reg;
    working_register_load_next = 1'b0;
    // no status flag output exists; flags never touched
    // a forced nop cycle issues no read or write
    if (!nop_reg)
    begin
      case (phase)
        BSC_Q1:
        begin
          // operand read issued for phase two
          if (kind == BSC_I_SKIP || kind == BSC_I_TOGGLE || kind == BSC_I_CLEAR)
            mem_rd_next = 1'b1;
        end
        BSC_Q2:
        begin
          data_next = mem_rdata;
        end
        BSC_Q3:
        begin
          if (kind == BSC_I_TOGGLE)
          begin
            mem_wdata_next = data_reg ^ bit_mask;
            mem_wr_next = 1'b1;
          end
          // clear writes zero in last phase
          else if (kind == BSC_I_CLEAR)
          begin
            mem_wdata_next = `BSC_BYTE_ZERO;
            mem_wr_next = 1'b1;
            // select zero also clears working register
            if (!sel_bit)
            begin
              working_register_next = `BSC_BYTE_ZERO;
              working_register_load_next = 1'b1;
            end
            // select one leaves working register alone
            else
              working_register_next = working_register_in;
          end
        end
        default:
        begin
          data_next = data_reg;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_reg <= `BSC_BYTE_ZERO;
      mem_addr_reg <= `BSC_BYTE_ZERO;
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      mem_wdata_reg <= `BSC_BYTE_ZERO;
      working_register_reg <= `BSC_BYTE_ZERO;
      working_register_load_reg <= 1'b0;
    end
    else
    begin
      data_reg <= data_next;
      mem_addr_reg <= mem_addr_next;
      mem_rd_reg <= mem_rd_next;
      mem_wr_reg <= mem_wr_next;
      mem_wdata_reg <= mem_wdata_next;
      working_register_reg <= working_register_next;
      working_register_load_reg <= working_register_load_next;
    end
  end

  // ==========================================
  // outputs, all from flip-flops
  assign mem_addr = mem_addr_reg;
  assign mem_rd = mem_rd_reg;
  assign mem_wr = mem_wr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign pc_out = pc_out_reg;
  assign pc_load = pc_load_reg;
  assign stack_top = stack_top_reg;
  assign stack_push = stack_push_reg;
  assign page_latch_out = page_latch_reg;
  assign page_latch_load = page_latch_load_reg;
  assign working_register_out = working_register_reg;
  assign working_register_load = working_register_load_reg;
  assign flush = flush_reg;
  assign phase_out = phase_reg;
  assign busy_nop = nop_reg;
endmodule : bsc_exec

// [bsc_params.svh]
// constants for the bit/skip/call/clear execute block
// assumes inclusion by every design file of this block
`ifndef BSC_PARAMS_SVH
`define BSC_PARAMS_SVH
`define BSC_OP_SKIP_SET 5'h12
`define BSC_OP_TOGGLE 5'h07
`define BSC_OP_CLEAR 7'h14
`define BSC_OP_CALL 3'h7
`define BSC_PAGE_LO 12
`define BSC_PAGE_HI 15
`define BSC_LIT_LO_TOP 7
`define BSC_BIT_IDX_LO 8
`define BSC_SEL_BIT 8
`define BSC_PC_RESET 16'h0000
`define BSC_BYTE_ZERO 8'h00
`define BSC_PC_STEP 16'h0001
`define BSC_PHASE_LAST 2'h3
`define BSC_PHASE_ONE 2'h1
`define BSC_PHASE_RESET 2'h0
`define BSC_BIT_ONE 8'h01
`endif

// [bsc_pkg.sv]
// types shared by the bit/skip/call/clear execute block
// assumes nothing beyond the params header
package bsc_pkg;
  typedef enum logic [1:0] {BSC_Q1, BSC_Q2, BSC_Q3, BSC_Q4} bsc_phase_t;
  typedef enum logic [2:0] {BSC_I_NONE, BSC_I_SKIP, BSC_I_TOGGLE, BSC_I_CALL,
    BSC_I_CLEAR} bsc_instr_t;
endpackage : bsc_pkg

// [bsc_phase_gen.sv]
// four-phase generator for the instruction cycle
// assumes one free running core clock
`timescale 1ns/1ps
`include "bsc_params.svh"
module bsc_phase_gen (
  input wire logic ref_clk, // core clock
  input wire logic rst_n, // async reset, active low
  output bsc_pkg::bsc_phase_t phase, // current phase
  output logic cycle_end // pulse in final phase
);
  import bsc_pkg::*;
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  always_comb
  begin
    cnt_next = cnt_reg + `BSC_PHASE_ONE;
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_reg <= `BSC_PHASE_RESET;
    else
      cnt_reg <= cnt_next;
  end
  assign phase = bsc_phase_t'(cnt_reg);
  assign cycle_end = (cnt_reg == `BSC_PHASE_LAST);
endmodule : bsc_phase_gen

// [bsc_decode.sv]
// opcode classifier for the four handled instructions
// assumes a 16-bit instruction word held stable over the cycle
`timescale 1ns/1ps
`include "bsc_params.svh"
module bsc_decode (
  input wire logic [15:0] instr, // instruction word
  output bsc_pkg::bsc_instr_t kind // decoded class
);
  import bsc_pkg::*;
  always_comb
  begin
    kind = BSC_I_NONE;
    if (instr[15:13] == `BSC_OP_CALL)
      kind = BSC_I_CALL;
    else if (instr[15:11] == `BSC_OP_SKIP_SET)
      kind = BSC_I_SKIP;
    else if (instr[15:11] == `BSC_OP_TOGGLE)
      kind = BSC_I_TOGGLE;
    else if (instr[15:9] == `BSC_OP_CLEAR)
      kind = BSC_I_CLEAR;
  end
endmodule : bsc_decode

// [bsc_exec_checker.sv]
// concurrent checks on the bsc_exec ports
// assumes instr and pc_in held over each four-clock cycle
`timescale 1ns/1ps
`include "bsc_params.svh"
module bsc_exec_checker
  import bsc_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic rst_n, // reset
  input wire logic [15:0] instr, // opcode
  input wire logic [15:0] pc_in, // pc
  input wire logic [7:0] page_latch_in, // latch in
  input wire logic [7:0] working_register_in, // working_register in
  input wire logic [7:0] mem_rdata, // rdata
  input wire logic [7:0] mem_addr, // addr
  input wire logic mem_rd, // read
  input wire logic mem_wr, // write
  input wire logic [7:0] mem_wdata, // wdata
  input wire logic [15:0] pc_out, // new pc
  input wire logic pc_load, // pc load
  input wire logic [15:0] stack_top, // pushed
  input wire logic stack_push, // push
  input wire logic [7:0] page_latch_out, // latch out
  input wire logic page_latch_load, // latch load
  input wire logic [7:0] working_register_out, // working_register out
  input wire logic working_register_load, // working_register load
  input wire logic flush, // discard
  input wire bsc_phase_t phase_out, // phase
  input wire logic busy_nop // nop cycle
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // phase_out lags the live phase by one clock
  a_rd_in_q2: assert property (mem_rd |-> phase_out == BSC_Q1) else $error("read off phase");
  a_wr_after_rd: assert property (mem_wr |-> $past(mem_rd, 2) && phase_out == BSC_Q3)
    else $error("write misplaced");
  a_stack_value: assert property (stack_push |-> stack_top == pc_in + 16'h0001)
    else $error("bad return address");
  a_push_first: assert property (pc_load |-> $past(stack_push)) else $error("no push");
  a_pc_target: assert property (pc_load |-> pc_out == {pc_in[15:13], $past(instr[12:0])})
    else $error("bad pc target");
  a_latch_copy: assert property (page_latch_load |->
    page_latch_out == {pc_in[15:13], $past(instr[12:8])}) else $error("bad latch");
  a_call_nop: assert property (pc_load |=> (flush && busy_nop) ##1 (busy_nop && !flush)[*3])
    else $error("call nop cycle wrong");
  a_flush_cause: assert property (flush |-> $past(mem_rd, 3) || $past(pc_load))
    else $error("flush without cause");
  a_nop_quiet: assert property (busy_nop |-> !(mem_rd || mem_wr || stack_push || pc_load))
    else $error("activity in nop");
  a_clear_zero: assert property (mem_wr && $past(instr[15:9]) == `BSC_OP_CLEAR
    |-> mem_wdata == 8'h00) else $error("clear not zero");
  a_working_register_sel: assert property (working_register_load |->
    !$past(instr[8]) && working_register_out == 8'h00) else $error("working_register clear wrong");
endmodule : bsc_exec_checker

bind bsc_exec bsc_exec_checker u_chk (.ref_clk, .rst_n, .instr, .pc_in, .page_latch_in,
  .working_register_in, .mem_rdata, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .pc_out,
  .pc_load, .stack_top, .stack_push, .page_latch_out, .page_latch_load,
  .working_register_out, .working_register_load, .flush, .phase_out, .busy_nop);

// [tb_bit_skip_call_clear_exec.sv]
// self-checking bench for bsc_exec
// assumes a fresh reset aligns each instruction with phase one
`timescale 1ns/1ps
`include "bsc_params.svh"
module tb_bit_skip_call_clear_exec;
  import bsc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] instr = 16'h0000, pc_in = 16'h0000, pc_out, stack_top;
  logic [7:0] page_latch_in = 8'h00, working_register_in = 8'h01, mem_rdata = 8'h00;
  logic [7:0] mem_addr, mem_wdata, page_latch_out, working_register_out, wdata, waddr;
  logic mem_rd, mem_wr, pc_load, stack_push, page_latch_load, working_register_load;
  logic flush, busy_nop;
  logic [6:0] seen;
  bsc_phase_t phase_out;
  int err_count = 0, check_count = 0, nop_n;
  int at [7];
  always #4 ref_clk = ~ref_clk;
  bsc_exec dut (.ref_clk, .rst_n, .instr, .pc_in, .page_latch_in, .working_register_in,
    .mem_rdata, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .pc_out, .pc_load, .stack_top,
    .stack_push, .page_latch_out, .page_latch_load, .working_register_out,
    .working_register_load, .flush, .phase_out, .busy_nop);
  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // ==========================================
  // one instruction from reset, strobes logged
  task automatic run(input logic [15:0] op, input logic [15:0] pc, input logic [7:0] rd);
    logic [6:0] s;
    @(posedge ref_clk);
    rst_n <= 1'b0;
    instr <= op;
    pc_in <= pc;
    mem_rdata <= rd;
    @(posedge ref_clk);
    rst_n <= 1'b1;
    seen = 7'h00;
    nop_n = 0;
    for (int i = 0; i < 10; i++)
    begin
      @(posedge ref_clk);
      // a held opcode would run twice
      if (i == 3)
        instr <= 16'h0000;
      #1;
      s = {mem_rd, mem_wr, stack_push, pc_load, page_latch_load, working_register_load, flush};
      for (int j = 0; j < 7; j++)
        if (s[j] === 1'b1)
        begin
          seen[j] = 1'b1;
          at[j] = i;
        end
      // address follows instr, so take it with the write strobe
      if (mem_wr === 1'b1)
      begin
        wdata = mem_wdata;
        waddr = mem_addr;
      end
      if (busy_nop === 1'b1)
        nop_n++;
    end
  endtask : run
  // ==========================================
  // toggle bit four, seven
  task automatic t_toggle();
    run(16'h3C5A, 16'h0100, 8'h75);
    check("toggle data", 16'(wdata), 16'h0065);
    check("toggle addr", 16'(waddr), 16'h005A);
    check("toggle gap", 16'(at[5] - at[6]), 16'd2);
    run(16'h3F11, 16'h0100, 8'h75);
    check("toggle bit7", 16'(wdata), 16'h00F5);
  endtask : t_toggle
  task automatic t_skip();
    run(16'h9133, 16'h0100, 8'h02);
    check("skip strobes", 16'(seen), 16'h0041);
    check("skip flush", 16'(at[0] - at[6]), 16'd3);
    check("skip nop", 16'(nop_n), 16'd4);
    run(16'h9133, 16'h0100, 8'hFD);
    check("fall strobes", 16'(seen), 16'h0040);
    check("fall nop", 16'(nop_n), 16'd0);
    run(16'h9833, 16'h0100, 8'hFF);
    check("other op", 16'(seen), 16'h0000);
  endtask : t_skip
  task automatic t_call();
    run(16'hF234, 16'hBFFF, 8'h00);
    check("call strobes", 16'(seen), 16'h001D);
    check("return addr", stack_top, 16'hC000);
    check("new pc", pc_out, 16'hB234);
    check("page latch", 16'(page_latch_out), 16'h00B2);
    check("push first", 16'(at[3] - at[4]), 16'd1);
    check("call nop", 16'(nop_n), 16'd4);
  endtask : t_call
  task automatic t_clear();
    run(16'h2866, 16'h0100, 8'hA5);
    check("clear both", 16'(seen), 16'h0062);
    check("clear data", 16'(wdata), 16'h0000);
    check("clear working_register", 16'(working_register_out), 16'h0000);
    check("clear addr", 16'(waddr), 16'h0066);
    check("clear working_register phase", 16'(at[1] - at[5]), 16'd0);
    run(16'h2966, 16'h0100, 8'hA5);
    check("clear only f", 16'(seen), 16'h0060);
  endtask : t_clear
  task automatic close_out();
    if (err_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_toggle();
    t_skip();
    t_call();
    t_clear();
    close_out();
  end
  // eight runs of twelve clocks fit well inside this
  initial
  begin
    #20000;
    err_count++;
    close_out();
  end
endmodule : tb_bit_skip_call_clear_exec
